// >>> design/aar_pkg.sv
// Constants, register map and types of the address resolver register block.
// Assumes one 25 MHz core clock and an APB master on the same clock.
// Contract
// - Writing one to bit 0 of the disable register clears the end enable.
// - Writing one to bit 1 of the disable register clears resolved enable.
// - Writing one to bit 2 of the disable register clears no-match enable.
// - Status reads the key index 0 to 15 of the last match, reset zero.
// - The resolver runs only while enable holds 3; 0 disables; reset 0.
// - Key count holds the keys in the table, 0 to 16, reset value 1.
// - Keys are fetched at the 32-bit key table pointer, reset zero.
// - The 6-byte address is read at the 32-bit address pointer.
// - Writing one to the begin task starts resolving against the keys in order, stopping at the first match.
// - Writing one to the halt task stops any ongoing resolution.
// - Finishing a resolution sets the end event flag to 1.
// - Set register writes of one enable; both enable registers read state.
package aar_pkg;
	localparam logic [11:0] OFS_BEGIN    = 12'h000;
	localparam logic [11:0] OFS_HALT     = 12'h008;
	localparam logic [11:0] OFS_EV_END   = 12'h100;
	localparam logic [11:0] OFS_EV_RES   = 12'h104;
	localparam logic [11:0] OFS_EV_NORES = 12'h108;
	localparam logic [11:0] OFS_INT_SET  = 12'h304;
	localparam logic [11:0] OFS_INT_DIS  = 12'h308;
	localparam logic [11:0] OFS_STATUS   = 12'h400;
	localparam logic [11:0] OFS_ENABLE   = 12'h500;
	localparam logic [11:0] OFS_KEY_CNT  = 12'h504;
	localparam logic [11:0] OFS_KEY_PTR  = 12'h508;
	localparam logic [11:0] OFS_ADDR_PTR = 12'h510;
	localparam logic [11:0] OFS_SCR_PTR  = 12'h514;
	localparam int          BIT_END      = 0;
	localparam int          BIT_RES      = 1;
	localparam int          BIT_NORES    = 2;
	localparam logic [1:0]  ENABLE_ON    = 2'h3;
	localparam logic [1:0]  ENABLE_RST   = 2'h0;
	localparam logic [4:0]  KEY_CNT_RST  = 5'h01;
	localparam logic [4:0]  KEY_CNT_MAX  = 5'h10;
	localparam logic [31:0] PTR_RST      = 32'h0000_0000;
	localparam logic [31:0] KEY_BYTES    = 32'h0000_0010;

	typedef enum logic [1:0] {
		AAR_IDLE,
		AAR_REQ,
		AAR_WAIT
	} aar_state_t;

	// Request to the key-check engine
	typedef struct packed {
		logic        req;
		logic [3:0]  index;
		logic [31:0] key_addr;
	} aar_check_t;

	// Events raised by the sequencer
	typedef struct packed {
		logic nores;
		logic res;
		logic done;
	} aar_events_t;
endpackage : aar_pkg

// >>> design/aar_regs.sv
// Address resolver: APB register bank, key sequencer and interrupt.
// Assumes an external key-check engine on core_clk that reads the key at
// the given address and the 6-byte address, and answers with a done pulse.
//
// Decided for this implementation: the APB slave port.
module aar_regs
	import aar_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	output aar_check_t       check,
	input  wire logic        check_done,
	input  wire logic        check_hit,
	output logic [31:0]      address_pointer,
	output logic [31:0]      scratch_pointer,
	output logic             busy,
	output logic             irq
);
	aar_state_t  state_reg, state_next;
	logic        pready_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	logic [2:0]  event_reg, event_next;
	logic [2:0]  inten_reg, inten_next;
	logic [3:0]  status_reg, status_next;
	logic [1:0]  enable_reg;
	logic [4:0]  key_count_reg;
	logic [31:0] key_ptr_reg;
	logic [31:0] addr_ptr_reg;
	logic [31:0] scr_ptr_reg;
	logic [3:0]  idx_reg, idx_next;
	logic        req_reg, req_next;
	logic [31:0] key_addr_reg;
	logic        irq_reg;
	logic        busy_reg;

	// APB decode: one wait state, so read data comes from a flip-flop
	wire access   = psel && penable;
	wire xfer     = access && pready_reg;
	wire wr_en    = xfer && pwrite;
	wire hit_beg  = paddr == OFS_BEGIN;
	wire hit_halt = paddr == OFS_HALT;
	wire hit_end  = paddr == OFS_EV_END;
	wire hit_res  = paddr == OFS_EV_RES;
	wire hit_nor  = paddr == OFS_EV_NORES;
	wire hit_set  = paddr == OFS_INT_SET;
	wire hit_dis  = paddr == OFS_INT_DIS;
	wire hit_stat = paddr == OFS_STATUS;
	wire hit_en   = paddr == OFS_ENABLE;
	wire hit_cnt  = paddr == OFS_KEY_CNT;
	wire hit_kptr = paddr == OFS_KEY_PTR;
	wire hit_aptr = paddr == OFS_ADDR_PTR;
	wire hit_sptr = paddr == OFS_SCR_PTR;
	wire mapped   = hit_beg | hit_halt | hit_end | hit_res | hit_nor
		| hit_set | hit_dis | hit_stat | hit_en | hit_cnt | hit_kptr
		| hit_aptr | hit_sptr;

	wire active     = enable_reg == ENABLE_ON;
	wire begin_task = wr_en && hit_beg && pwdata[0] && active;
	wire halt_task  = wr_en && hit_halt && pwdata[0];
	wire [4:0] idx_wide  = {1'b0, idx_reg};
	wire       last_key  = idx_wide + 5'h01 >= key_count_reg;
	wire       empty_tab = key_count_reg == 5'h00;

	wire [31:0] rd_data =
		hit_end  ? {31'h0, event_reg[BIT_END]} :
		hit_res  ? {31'h0, event_reg[BIT_RES]} :
		hit_nor  ? {31'h0, event_reg[BIT_NORES]} :
		(hit_set | hit_dis) ? {29'h0, inten_reg} :
		hit_stat ? {28'h0, status_reg} :
		hit_en   ? {30'h0, enable_reg} :
		hit_cnt  ? {27'h0, key_count_reg} :
		hit_kptr ? key_ptr_reg :
		hit_aptr ? addr_ptr_reg :
		hit_sptr ? scr_ptr_reg : 32'h0000_0000;

	// Sequencer: one check request per key, stops on first match
	aar_events_t ev;
	always_comb begin
		state_next  = state_reg;
		idx_next    = idx_reg;
		req_next    = 1'b0;
		status_next = status_reg;
		ev          = '0;
		unique case (state_reg)
			AAR_IDLE: begin
				if (begin_task && empty_tab) begin
					ev.nores = 1'b1;
					ev.done  = 1'b1;
				end else if (begin_task) begin
					idx_next   = 4'h0;
					req_next   = 1'b1;
					state_next = AAR_REQ;
				end
			end
			AAR_REQ: begin
				state_next = AAR_WAIT;
			end
			AAR_WAIT: begin
				if (check_done && check_hit) begin
					status_next = idx_reg;
					ev.res      = 1'b1;
					ev.done     = 1'b1;
					state_next  = AAR_IDLE;
				end else if (check_done && last_key) begin
					ev.nores   = 1'b1;
					ev.done    = 1'b1;
					state_next = AAR_IDLE;
				end else if (check_done) begin
					idx_next   = idx_reg + 4'h1;
					req_next   = 1'b1;
					state_next = AAR_REQ;
				end
			end
		endcase
		// Halt or disable aborts without raising events
		if (halt_task || !active) begin
			state_next = AAR_IDLE;
			req_next   = 1'b0;
			ev         = '0;
		end
	end

	// Event flags: hardware set wins over a software write of zero
	wire [2:0] ev_set = {ev.nores, ev.res, ev.done};
	wire [2:0] ev_clr = {wr_en && hit_nor && !pwdata[0],
		wr_en && hit_res && !pwdata[0],
		wr_en && hit_end && !pwdata[0]};
	assign event_next = (event_reg & ~ev_clr) | ev_set;

	// Enables: ones set or clear, zeros leave a bit alone
	wire [2:0] en_set = wr_en && hit_set ? pwdata[2:0] : 3'h0;
	wire [2:0] en_clr = wr_en && hit_dis ? pwdata[2:0] : 3'h0;
	assign inten_next = (inten_reg | en_set) & ~en_clr;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= access && !pready_reg;
			prdata_reg  <= access && !pwrite ? rd_data : 32'h0000_0000;
			pslverr_reg <= access && !pready_reg && !mapped;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_reg    <= ENABLE_RST;
			key_count_reg <= KEY_CNT_RST;
			key_ptr_reg   <= PTR_RST;
			addr_ptr_reg  <= PTR_RST;
			scr_ptr_reg   <= PTR_RST;
		end else if (wr_en) begin
			if (hit_en)
				enable_reg <= pwdata[1:0];
			if (hit_cnt && pwdata[4:0] <= KEY_CNT_MAX)
				key_count_reg <= pwdata[4:0];
			if (hit_kptr)
				key_ptr_reg <= pwdata;
			if (hit_aptr)
				addr_ptr_reg <= pwdata;
			if (hit_sptr)
				scr_ptr_reg <= pwdata;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= AAR_IDLE;
			idx_reg      <= 4'h0;
			req_reg      <= 1'b0;
			key_addr_reg <= PTR_RST;
			status_reg   <= 4'h0;
			event_reg    <= 3'h0;
			inten_reg    <= 3'h0;
			irq_reg      <= 1'b0;
			busy_reg     <= 1'b0;
		end else begin
			state_reg    <= state_next;
			idx_reg      <= idx_next;
			req_reg      <= req_next;
			key_addr_reg <= key_ptr_reg
				+ KEY_BYTES * {28'h0, idx_next};
			status_reg   <= status_next;
			event_reg    <= event_next;
			inten_reg    <= inten_next;
			irq_reg      <= |(event_next & inten_next);
			busy_reg     <= state_next != AAR_IDLE;
		end
	end

	assign pready          = pready_reg;
	assign prdata          = prdata_reg;
	assign pslverr         = pslverr_reg;
	assign check.req       = req_reg;
	assign check.index     = idx_reg;
	assign check.key_addr  = key_addr_reg;
	assign address_pointer = addr_ptr_reg;
	assign scratch_pointer = scr_ptr_reg;
	assign busy            = busy_reg;
	assign irq             = irq_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	dis_end_a: assert property (wr_en && hit_dis && pwdata[BIT_END]
		|=> !inten_reg[BIT_END])
		else $error("end enable not cleared");
	dis_res_a: assert property (wr_en && hit_dis && pwdata[BIT_RES]
		|=> !inten_reg[BIT_RES])
		else $error("resolved enable not cleared");
	dis_nores_a: assert property (wr_en && hit_dis && pwdata[BIT_NORES]
		|=> !inten_reg[BIT_NORES])
		else $error("no-match enable not cleared");
	status_match_a: assert property (state_reg == AAR_WAIT && check_done
		&& check_hit && active && !halt_task
		|=> status_reg == $past(idx_reg) && event_reg[BIT_RES])
		else $error("status not loaded on match");
	inactive_idle_a: assert property (!active |=> state_reg == AAR_IDLE
		&& !req_reg)
		else $error("resolver running while disabled");
	count_range_a: assert property (key_count_reg <= KEY_CNT_MAX)
		else $error("key count out of range");
	key_addr_a: assert property (req_reg |-> key_addr_reg ==
		key_ptr_reg + KEY_BYTES * {28'h0, idx_reg})
		else $error("wrong key address");
	begin_req_a: assert property (begin_task && !halt_task
		&& state_reg == AAR_IDLE && !empty_tab
		|=> req_reg && idx_reg == 4'h0 ##1 state_reg == AAR_WAIT)
		else $error("begin task did not start a walk");
	halt_idle_a: assert property (halt_task |=> state_reg == AAR_IDLE
		##1 !req_reg)
		else $error("halt task did not stop");
	end_event_a: assert property (state_reg == AAR_WAIT && check_done
		&& (check_hit || last_key) && active && !halt_task
		|=> event_reg[BIT_END] && state_reg == AAR_IDLE)
		else $error("end event missing");
	set_keep_a: assert property (wr_en && hit_dis && !pwdata[BIT_END]
		&& !ev.done |=> inten_reg[BIT_END] == $past(inten_reg[BIT_END]))
		else $error("zero write changed an enable");
	irq_level_a: assert property (##1 irq == |$past(event_next
		& inten_next))
		else $error("interrupt level wrong");

	busy_track_a: assert property (busy == (state_reg != AAR_IDLE))
		else $error("busy does not follow the sequencer");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready stood longer than one cycle");
	halt_quiet_a: assert property (halt_task |=> !event_reg[BIT_END]
		|| $past(event_reg[BIT_END]))
		else $error("halt raised an end event");

	walk_hit_c: cover property (begin_task ##[1:40] check_done
		&& check_hit);
	walk_miss_c: cover property (ev.nores && key_count_reg == KEY_CNT_MAX);
	irq_c: cover property (irq ##[1:20] !irq);
	halt_c: cover property (state_reg == AAR_WAIT && halt_task);
endmodule : aar_regs

// >>> bench/aar_engine_model.sv
// Key-check engine model: answers each check request after a set delay.
// Assumes requests come from the register block on the same core clock.
module aar_engine_model
	import aar_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  aar_check_t       check,
	input  wire logic [4:0]  hit_index,
	input  wire logic [7:0]  delay,
	output logic             check_done,
	output logic             check_hit,
	output logic [31:0]      last_key_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_reg;
	logic [3:0] idx_reg;

	// Hit line toggles outside the answer so a stale value is never trusted
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_reg <= 8'h00;
			idx_reg <= 4'h0;
			check_done <= 1'b0;
			check_hit <= 1'b0;
			last_key_addr <= 32'h0000_0000;
		end else begin
			check_done <= (cnt_reg == 8'h01);
			check_hit <= (cnt_reg == 8'h01) ? ({1'b0, idx_reg} == hit_index)
				: ~check_hit;
			if (check.req) begin
				cnt_reg <= delay;
				idx_reg <= check.index;
				last_key_addr <= check.key_addr;
			end else if (cnt_reg != 8'h00) begin
				cnt_reg <= cnt_reg - 8'h01;
			end
		end
	end
endmodule : aar_engine_model

// >>> bench/aar_regs_tb_top.sv
// Self-checking bench of the address resolver register block.
// Assumes the engine model stands in for the key-check engine.
module aar_regs_tb_top
	import aar_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic        busy, irq, check_done, check_hit, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, address_pointer, scratch_pointer, key_seen, rd;
	aar_check_t  check;
	logic [4:0]  hit_index;
	logic [7:0]  delay;
	int          bad_count, n_checks, cycles;

	aar_regs dut_u (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .check(check),
		.check_done(check_done), .check_hit(check_hit), .busy(busy), .irq(irq),
		.address_pointer(address_pointer), .scratch_pointer(scratch_pointer));
	aar_engine_model eng_u (.core_clk(core_clk), .reset_n(reset_n),
		.check(check), .hit_index(hit_index), .delay(delay),
		.check_done(check_done), .check_hit(check_hit),
		.last_key_addr(key_seen));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			close_out;
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	task wait_idle;
		@(posedge core_clk);
		for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge core_clk);
	endtask : wait_idle

	task t_reset;
		rdchk(OFS_STATUS, 32'h0);
		rdchk(OFS_ENABLE, 32'h0);
		rdchk(OFS_KEY_CNT, 32'h1);
		rdchk(OFS_KEY_PTR, 32'h0);
		rdchk(OFS_INT_DIS, 32'h0);
	endtask : t_reset

	task t_ptrs;
		apb(1'b1, OFS_KEY_PTR, 32'h2000_0100);
		rdchk(OFS_KEY_PTR, 32'h2000_0100);
		apb(1'b1, OFS_ADDR_PTR, 32'h2000_0A04);
		@(posedge core_clk);
		chk(address_pointer, 32'h2000_0A04);
		apb(1'b1, OFS_SCR_PTR, 32'h2000_0C00);
		@(posedge core_clk);
		chk(scratch_pointer, 32'h2000_0C00);
		apb(1'b1, OFS_KEY_CNT, 32'h11);
		rdchk(OFS_KEY_CNT, 32'h1);
		apb(1'b0, 12'h0FC, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask : t_ptrs

	task t_inten;
		apb(1'b1, OFS_INT_SET, 32'h7);
		rdchk(OFS_INT_SET, 32'h7);
		apb(1'b1, OFS_INT_DIS, 32'h0);
		rdchk(OFS_INT_DIS, 32'h7);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, OFS_INT_DIS, 32'h1 << i);
			rdchk(OFS_INT_SET, 32'h7 & ~((32'h2 << i) - 32'h1));
		end
	endtask : t_inten

	task t_resolve(input logic [4:0] hit, input logic [4:0] cnt);
		logic [4:0] idx;
		idx = (hit < cnt) ? hit : cnt - 5'h01;
		hit_index <= hit;
		apb(1'b1, OFS_ENABLE, 32'h3);
		apb(1'b1, OFS_KEY_CNT, {27'h0, cnt});
		apb(1'b1, OFS_INT_SET, 32'h7);
		apb(1'b1, OFS_BEGIN, 32'h1);
		wait_idle;
		rdchk(OFS_EV_END, 32'h1);
		rdchk(OFS_EV_RES, {31'h0, hit < cnt});
		rdchk(OFS_EV_NORES, {31'h0, hit >= cnt});
		if (hit < cnt) rdchk(OFS_STATUS, {27'h0, hit});
		chk(key_seen, 32'h2000_0100 + {23'h0, idx, 4'h0});
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFS_INT_DIS, 32'h7);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, OFS_EV_END, 32'h0);
		apb(1'b1, OFS_EV_RES, 32'h0);
		apb(1'b1, OFS_EV_NORES, 32'h0);
	endtask : t_resolve

	task t_halt;
		delay <= 8'd40;
		hit_index <= 5'h00;
		apb(1'b1, OFS_BEGIN, 32'h1);
		apb(1'b1, OFS_HALT, 32'h1);
		repeat (60) @(posedge core_clk);
		chk({31'h0, busy}, 32'h0);
		rdchk(OFS_EV_END, 32'h0);
		apb(1'b1, OFS_ENABLE, 32'h2);
		apb(1'b1, OFS_BEGIN, 32'h1);
		repeat (3) @(posedge core_clk);
		chk({31'h0, busy}, 32'h0);
	endtask : t_halt

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out

	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		hit_index = 5'h10;
		delay = 8'd2;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset;
		t_ptrs;
		t_inten;
		t_resolve(5'd15, 5'd16);
		t_resolve(5'h10, 5'd3);
		t_halt;
		close_out;
	end
endmodule : aar_regs_tb_top
